//--- flash_protect_pkg.sv
// Shared constants for the flash program/erase protection block.
// Assumes a 25 MHz system clock and an AXI4-Lite register port.
package flash_protect_pkg;

  // Register bus geometry
  localparam int         AXI_AW         = 8;       // Byte address width
  localparam logic [7:0] OFF_CTRL_LOW   = 8'h00;   // flash_control_low
  localparam logic [7:0] OFF_CTRL_HIGH  = 8'h04;   // flash_control_high
  localparam logic [7:0] OFF_EBS_ONE    = 8'h08;   // erase_block_select_one
  localparam logic [7:0] OFF_EBS_TWO    = 8'h0c;   // erase_block_select_two
  localparam logic [7:0] OFF_EMU        = 8'h10;   // emulation_register
  localparam logic [7:0] OFF_STATUS     = 8'h14;   // Mode and error status
  localparam logic [1:0] RESP_OKAY      = 2'h0;    // AXI OKAY
  localparam logic [1:0] RESP_SLVERR    = 2'h2;    // AXI SLVERR, unmapped

  // Control register fields, same layout in both areas
  localparam int         BIT_PROG       = 0;       // Program bit
  localparam int         BIT_ERASE      = 1;       // Erase bit
  localparam int         BIT_PVER       = 2;       // Program-verify bit
  localparam int         BIT_EVER       = 3;       // Erase-verify bit
  localparam int         BIT_WE         = 6;       // Area write enable
  localparam int         BIT_ERR        = 7;       // Error flag, high reg only
  localparam logic [7:0] CTRL_WMASK     = 8'h4f;   // Writable control bits

  // Emulation register fields
  localparam int         EMU_SEL_BIT    = 3;       // emulation_select
  localparam int         OVL_SEL_W      = 3;       // overlay_block_select width

  // Reset values
  localparam logic [7:0] CTRL_RESET     = 8'h00;
  localparam logic [7:0] EBS_RESET      = 8'h00;
  localparam logic [3:0] EMU_RESET      = 4'h0;

  // Flash address map
  localparam logic [31:0] AREA_LOW_BASE  = 32'h0000_0000;
  localparam logic [31:0] AREA_LOW_LAST  = 32'h0003_ffff;
  localparam logic [31:0] AREA_HIGH_BASE = 32'h0004_0000;
  localparam logic [31:0] AREA_HIGH_LAST = 32'h0007_ffff;
  localparam int          AREA_BIT       = 18;     // Selects low/high area
  localparam int          BLK_LSB        = 15;     // 32 KB erase blocks
  localparam int          OVL_WIN_W      = 12;     // 4 KB overlay window
  localparam logic [31:0] RAM_OVL_BASE   = 32'hffff_f000;

  // Software recovery time after clearing area write enable
  localparam int CLK_MHZ     = 25;
  localparam int WRITE_ENABLE_CLEAR_RECOVERY_US   = 100;
  localparam int CSWE_CYCLES = WRITE_ENABLE_CLEAR_RECOVERY_US * CLK_MHZ;

endpackage : flash_protect_pkg

//--- area_gate.sv
// Entry gate for program, erase and verify modes of one flash area.
// Purely combinational; the caller registers the results.
`timescale 1ns/1ps
module area_gate (
  // Stored control state of the area
  input  wire logic       we,
  input  wire logic       prog_bit,
  input  wire logic       erase_bit,
  input  wire logic       pver_bit,
  input  wire logic       ever_bit,
  input  wire logic [7:0] blocks,
  // Global protection state
  input  wire logic       emu_sel,
  input  wire logic       err,
  // Gate results
  output logic            sw_protect,
  output logic            prog_ok,
  output logic            erase_ok,
  output logic            verify_ok
);

  // Software protection: area locked or emulation running
  assign sw_protect = ~we | emu_sel;

  // Program needs open area and no error protection
  assign prog_ok    = ~sw_protect & ~err & prog_bit;

  // Erase also needs a selected block in this area
  assign erase_ok   = ~sw_protect & ~err & erase_bit & (|blocks);

  // Verify stays reachable under error protection
  assign verify_ok  = we & (pver_bit | ever_bit);

endmodule : area_gate

//--- overlay_map.sv
// RAM overlay decode: maps a window of RAM over one flash block.
// Combinational; the address comes from the CPU on the same clock.
`timescale 1ns/1ps
module overlay_map (
  // Overlay setup
  input  wire logic        emu_sel,
  input  wire logic [2:0]  ovl_sel,
  input  wire logic        user_mode_ok,
  // CPU address
  input  wire logic [31:0] cpu_addr,
  // Decode results
  output logic             redirect,
  output logic             refuse,
  output logic [31:0]      ram_addr
);

  logic        active;    // Overlay in force
  logic [31:0] blk_base;  // Base of the overlaid block

  // Only in user or user program mode; clearing select releases it
  assign active   = emu_sel & user_mode_ok;

  // Select value zero picks erase_block_zero
  assign blk_base = {29'h0, ovl_sel} << flash_protect_pkg::BLK_LSB;

  // Flash reads of the window go to RAM instead
  assign redirect = active &
    (cpu_addr[31:flash_protect_pkg::OVL_WIN_W] ==
     blk_base[31:flash_protect_pkg::OVL_WIN_W]);

  // Direct access to the overlapping RAM is refused
  assign refuse   = active &
    (cpu_addr[31:flash_protect_pkg::OVL_WIN_W] ==
     flash_protect_pkg::RAM_OVL_BASE[31:flash_protect_pkg::OVL_WIN_W]);

  // RAM address seen through the window
  assign ram_addr = flash_protect_pkg::RAM_OVL_BASE |
    {20'h0, cpu_addr[flash_protect_pkg::OVL_WIN_W-1:0]};

endmodule : overlay_map

//--- flash_protect.sv
// Flash program/erase protection: registers, mode gating, error lock.
// Assumes CPU event inputs on this clock, pins raw, AXI4-Lite master.
//
// Functional notes
// - Low area locked while its enable clear
// - High area locked while its enable clear
// - Protected: program/erase bits ignored, no program or erase mode
// - Erase per selected block; none selected blocks all
// - Emulation select locks every block
// - Malfunction sets error flag, enters error protection
// - Error keeps registers, aborts active mode
// - Under error no program or erase entry
// - Under error verify bits still work
// - Flash read of busy area raises error
// - Sleep during program/erase raises error
// - Only power-on reset or standby clears error
// - Emulation register maps RAM over flash block
// - Overlaid flash and overlapping RAM blocked
// - Overlay only in user modes
// - Select zero overlays erase block zero
// - Clearing emulation select releases overlay
//
// Decided for this implementation: the address map and register access over AXI4-Lite.
`timescale 1ns/1ps
module flash_protect (
  // Clock, reset, enable
  input  wire logic        clock,
  input  wire logic        reset_n,
  input  wire logic        ce,
  // AXI4-Lite write channels
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  // AXI4-Lite read channels
  input  wire logic [7:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  // CPU events, same clock
  input  wire logic        cpu_read,
  input  wire logic [31:0] cpu_addr,
  input  wire logic        cpu_sleep,
  // Pins from outside the clock domain
  input  wire logic        hw_standby,
  input  wire logic        user_mode,
  // Flash array controls
  output logic [1:0]       program_mode,
  output logic [1:0]       erase_mode,
  output logic [1:0]       verify_mode,
  output logic [15:0]      erase_target,
  output logic             flash_error_flag,
  // Overlay decode
  output logic             ovl_redirect,
  output logic             ovl_refuse,
  output logic [31:0]      ovl_ram_addr
);

  // Whole state of the block
  typedef struct packed {
    logic            stby_s1;      // Standby sync stage one
    logic            stby_s2;      // Standby sync stage two
    logic            umode_s1;     // User mode sync stage one
    logic            umode_s2;     // User mode sync stage two
    logic [1:0][7:0] ctl;          // Control registers per area
    logic [1:0][7:0] ebs;          // Block select registers
    logic [3:0]      emu;          // Emulation register
    logic            err;          // Flash error flag
    logic [1:0]      prg;          // Program mode per area
    logic [1:0]      ers;          // Erase mode per area
    logic [1:0]      ver;          // Verify mode per area
    logic [15:0]     ers_tgt;      // Blocks under erase
    logic            ovl_redirect; // Registered overlay hit
    logic            ovl_refuse;   // Registered RAM refusal
    logic [31:0]     ovl_ram_addr; // Registered RAM address
    logic            awready;      // AXI write address ready
    logic            wready;       // AXI write data ready
    logic            aw_got;       // Address held
    logic            w_got;        // Data held
    logic            w_en;         // Low byte lane enabled
    logic [7:0]      aw_addr;      // Held write address
    logic [7:0]      w_data;       // Held write data
    logic            bvalid;       // Write response valid
    logic [1:0]      bresp;        // Write response code
    logic            arready;      // Read address ready
    logic            rvalid;       // Read data valid
    logic [1:0]      rresp;        // Read response code
    logic [31:0]     rdata;        // Read data
  } state_s;

  state_s      st_ff;       // Registered state
  state_s      nxt_st;      // Next state
  logic [1:0]  sw_prot;     // Software protection per area
  logic [1:0]  prog_ok;     // Program entry allowed
  logic [1:0]  erase_ok;    // Erase entry allowed
  logic [1:0]  verify_ok;   // Verify entry allowed
  logic        ovl_hit_c;   // Overlay decode, unregistered
  logic        ovl_ref_c;   // RAM refusal, unregistered
  logic [31:0] ovl_addr_c;  // RAM address, unregistered
  logic [7:0]  wdat;        // Control write after masking
  logic        cpu_area;    // Area of CPU address
  logic        in_flash;    // CPU address inside flash
  logic        rd_err;      // Busy-area read event
  logic        sleep_err;   // Sleep during operation event

  // Offset decode shared by read and write
  function automatic logic reg_mapped(input logic [7:0] a);
    return (a == flash_protect_pkg::OFF_CTRL_LOW) || (a == flash_protect_pkg::OFF_CTRL_HIGH) ||
           (a == flash_protect_pkg::OFF_EBS_ONE)  || (a == flash_protect_pkg::OFF_EBS_TWO)  ||
           (a == flash_protect_pkg::OFF_EMU)      || (a == flash_protect_pkg::OFF_STATUS);
  endfunction : reg_mapped

  // Read mux; error flag comes from its own flop only
  function automatic logic [31:0] read_word(input state_s s, input logic [7:0] a);
    logic [31:0] v;
    v = 32'h0;
    case (a)
      flash_protect_pkg::OFF_CTRL_LOW:  v = {24'h0, s.ctl[0]};
      flash_protect_pkg::OFF_CTRL_HIGH: v = {24'h0, s.err, s.ctl[1][6:0]};
      flash_protect_pkg::OFF_EBS_ONE:   v = {24'h0, s.ebs[0]};
      flash_protect_pkg::OFF_EBS_TWO:   v = {24'h0, s.ebs[1]};
      flash_protect_pkg::OFF_EMU:       v = {28'h0, s.emu};
      flash_protect_pkg::OFF_STATUS:    v = {24'h0, s.err, 1'b0, s.ver, s.ers, s.prg};
      default:                          v = 32'h0;
    endcase
    return v;
  endfunction : read_word

  // Entry gates, one per area
  for (genvar g = 0; g < 2; g++) begin : g_area
    area_gate u_gate (
      .we         (st_ff.ctl[g][flash_protect_pkg::BIT_WE]),
      .prog_bit   (st_ff.ctl[g][flash_protect_pkg::BIT_PROG]),
      .erase_bit  (st_ff.ctl[g][flash_protect_pkg::BIT_ERASE]),
      .pver_bit   (st_ff.ctl[g][flash_protect_pkg::BIT_PVER]),
      .ever_bit   (st_ff.ctl[g][flash_protect_pkg::BIT_EVER]),
      .blocks     (st_ff.ebs[g]),
      .emu_sel    (st_ff.emu[flash_protect_pkg::EMU_SEL_BIT]),
      .err        (st_ff.err),
      .sw_protect (sw_prot[g]),
      .prog_ok    (prog_ok[g]),
      .erase_ok   (erase_ok[g]),
      .verify_ok  (verify_ok[g])
    );
  end

  // RAM overlay decode
  overlay_map u_overlay (
    .emu_sel      (st_ff.emu[flash_protect_pkg::EMU_SEL_BIT]),
    .ovl_sel      (st_ff.emu[flash_protect_pkg::OVL_SEL_W-1:0]),
    .user_mode_ok (st_ff.umode_s2),
    .cpu_addr     (cpu_addr),
    .redirect     (ovl_hit_c),
    .refuse       (ovl_ref_c),
    .ram_addr     (ovl_addr_c)
  );

  // Next-state logic for bus, registers, error lock and modes
  always_comb begin
    nxt_st    = st_ff;
    wdat      = 8'h00;
    cpu_area  = cpu_addr[flash_protect_pkg::AREA_BIT];
    in_flash  = (cpu_addr <= flash_protect_pkg::AREA_HIGH_LAST);
    rd_err    = 1'b0;
    sleep_err = 1'b0;

    // Pin synchronisers
    nxt_st.stby_s1  = hw_standby;
    nxt_st.stby_s2  = st_ff.stby_s1;
    nxt_st.umode_s1 = user_mode;
    nxt_st.umode_s2 = st_ff.umode_s1;

    // Address and data are taken in either order
    if (s_axi_awvalid && st_ff.awready) begin
      nxt_st.aw_got  = 1'b1;
      nxt_st.aw_addr = s_axi_awaddr;
    end
    if (s_axi_wvalid && st_ff.wready) begin
      nxt_st.w_got  = 1'b1;
      nxt_st.w_data = s_axi_wdata[7:0];
      nxt_st.w_en   = s_axi_wstrb[0];
    end
    if (st_ff.bvalid && s_axi_bready) begin
      nxt_st.bvalid = 1'b0;
    end

    // Both halves held: commit the write and answer
    if (st_ff.aw_got && st_ff.w_got && !st_ff.bvalid) begin
      nxt_st.aw_got = 1'b0;
      nxt_st.w_got  = 1'b0;
      nxt_st.bvalid = 1'b1;
      nxt_st.bresp  = reg_mapped(st_ff.aw_addr) ? flash_protect_pkg::RESP_OKAY
                                                : flash_protect_pkg::RESP_SLVERR;
      if (st_ff.w_en) begin
        for (int a = 0; a < 2; a++) begin
          // Control write; error bit is never written
          if (st_ff.aw_addr == (a == 0 ? flash_protect_pkg::OFF_CTRL_LOW
                                       : flash_protect_pkg::OFF_CTRL_HIGH)) begin
            wdat = st_ff.w_data & flash_protect_pkg::CTRL_WMASK;
            // Protected area drops program and erase requests
            if (sw_prot[a]) begin
              wdat[flash_protect_pkg::BIT_PROG]  = 1'b0;
              wdat[flash_protect_pkg::BIT_ERASE] = 1'b0;
            end
            nxt_st.ctl[a] = wdat;
          end
          // Block select write
          if (st_ff.aw_addr == (a == 0 ? flash_protect_pkg::OFF_EBS_ONE
                                       : flash_protect_pkg::OFF_EBS_TWO)) begin
            nxt_st.ebs[a] = st_ff.w_data;
          end
        end
        // Emulation register write
        if (st_ff.aw_addr == flash_protect_pkg::OFF_EMU) begin
          nxt_st.emu = st_ff.w_data[3:0];
        end
      end
    end
    // Each ready only while its own half is not held and no response is pending
    nxt_st.awready = !nxt_st.aw_got && !nxt_st.bvalid;
    nxt_st.wready  = !nxt_st.w_got && !nxt_st.bvalid;

    // Read channel, one read in flight
    if (st_ff.rvalid && s_axi_rready) begin
      nxt_st.rvalid = 1'b0;
    end
    if (s_axi_arvalid && st_ff.arready) begin
      nxt_st.rvalid = 1'b1;
      nxt_st.rdata  = read_word(st_ff, s_axi_araddr);
      nxt_st.rresp  = reg_mapped(s_axi_araddr) ? flash_protect_pkg::RESP_OKAY
                                               : flash_protect_pkg::RESP_SLVERR;
    end
    nxt_st.arready = !nxt_st.rvalid;

    // Reading the busy area, fetches included, is a malfunction
    rd_err    = cpu_read && in_flash && (st_ff.prg[cpu_area] || st_ff.ers[cpu_area]);
    // Sleep or software standby while busy is a malfunction
    sleep_err = cpu_sleep && ((|st_ff.prg) || (|st_ff.ers));
    // Error is sticky; registers are left untouched
    if (rd_err || sleep_err) begin
      nxt_st.err = 1'b1;
    end

    // Hardware standby clears registers and the error lock
    if (st_ff.stby_s2) begin
      nxt_st.ctl = {2{flash_protect_pkg::CTRL_RESET}};
      nxt_st.ebs = {2{flash_protect_pkg::EBS_RESET}};
      nxt_st.emu = flash_protect_pkg::EMU_RESET;
      nxt_st.err = 1'b0;
    end

    // Modes follow the gates; an error aborts program and erase at once
    for (int a = 0; a < 2; a++) begin
      nxt_st.prg[a] = prog_ok[a] && !nxt_st.err && !st_ff.stby_s2;
      nxt_st.ers[a] = erase_ok[a] && !nxt_st.err && !st_ff.stby_s2;
      nxt_st.ver[a] = verify_ok[a] && !st_ff.stby_s2;
    end
    // Only selected blocks see the erase
    nxt_st.ers_tgt = {st_ff.ebs[1] & {8{nxt_st.ers[1]}},
                      st_ff.ebs[0] & {8{nxt_st.ers[0]}}};

    // Overlay results registered so outputs come from flops
    nxt_st.ovl_redirect = ovl_hit_c;
    nxt_st.ovl_refuse   = ovl_ref_c;
    nxt_st.ovl_ram_addr = ovl_addr_c;
  end

  // State register; reset is power-on, clock enable freezes all
  always_ff @(posedge clock) begin
    if (!reset_n) begin
      st_ff <= '0;
    end else if (ce) begin
      st_ff <= nxt_st;
    end
  end

  // Outputs straight from flops
  assign s_axi_awready    = st_ff.awready;
  assign s_axi_wready     = st_ff.wready;
  assign s_axi_bresp      = st_ff.bresp;
  assign s_axi_bvalid     = st_ff.bvalid;
  assign s_axi_arready    = st_ff.arready;
  assign s_axi_rdata      = st_ff.rdata;
  assign s_axi_rresp      = st_ff.rresp;
  assign s_axi_rvalid     = st_ff.rvalid;
  assign program_mode     = st_ff.prg;
  assign erase_mode       = st_ff.ers;
  assign verify_mode      = st_ff.ver;
  assign erase_target     = st_ff.ers_tgt;
  assign flash_error_flag = st_ff.err;
  assign ovl_redirect     = st_ff.ovl_redirect;
  assign ovl_refuse       = st_ff.ovl_refuse;
  assign ovl_ram_addr     = st_ff.ovl_ram_addr;

  // Low area locked one cycle after its enable is clear
  a_low_area_guard : assert property (
    @(posedge clock) disable iff (!reset_n)
    $past(ce && !st_ff.ctl[0][flash_protect_pkg::BIT_WE]) |-> !st_ff.prg[0] && !st_ff.ers[0])
    else $error("low area mode while write enable clear");

  // High area likewise
  a_high_area_guard : assert property (
    @(posedge clock) disable iff (!reset_n)
    $past(ce && !st_ff.ctl[1][flash_protect_pkg::BIT_WE]) |-> !st_ff.prg[1] && !st_ff.ers[1])
    else $error("high area mode while write enable clear");

  // Emulation select locks every block
  a_emu_lock_all : assert property (
    @(posedge clock) disable iff (!reset_n)
    $past(ce && st_ff.emu[flash_protect_pkg::EMU_SEL_BIT]) |-> (st_ff.prg == 2'h0) &&
    (st_ff.ers == 2'h0))
    else $error("mode entered under emulation select");

  // No block selected means no erase
  a_no_block_erase : assert property (
    @(posedge clock) disable iff (!reset_n)
    $past(ce && st_ff.ebs[0] == 8'h00 && st_ff.ebs[1] == 8'h00) |-> st_ff.ers == 2'h0)
    else $error("erase with no block selected");

  // Busy-area read raises the flag next cycle
  a_read_sets_err : assert property (
    @(posedge clock) disable iff (!reset_n)
    ce && cpu_read && in_flash && (st_ff.prg[cpu_area] || st_ff.ers[cpu_area]) &&
    !st_ff.stby_s2 |=> st_ff.err && st_ff.prg == 2'h0 && st_ff.ers == 2'h0)
    else $error("busy area read did not raise error");

  // Sleep while busy raises the flag next cycle
  a_sleep_sets_err : assert property (
    @(posedge clock) disable iff (!reset_n)
    ce && cpu_sleep && (st_ff.prg != 2'h0 || st_ff.ers != 2'h0) && !st_ff.stby_s2
    |=> st_ff.err)
    else $error("sleep while busy did not raise error");

  // Error stays until standby or reset
  a_error_sticky : assert property (
    @(posedge clock) disable iff (!reset_n)
    st_ff.err && !st_ff.stby_s2 |=> st_ff.err)
    else $error("error flag cleared without standby");

  // No program or erase while error stands
  a_no_reentry : assert property (
    @(posedge clock) disable iff (!reset_n)
    st_ff.err |-> st_ff.prg == 2'h0 && st_ff.ers == 2'h0)
    else $error("mode active under error protection");

  // Verify still entered under error
  a_verify_in_err : assert property (
    @(posedge clock) disable iff (!reset_n)
    $past(ce && st_ff.err && !st_ff.stby_s2 && st_ff.ctl[0][flash_protect_pkg::BIT_WE] &&
    st_ff.ctl[0][flash_protect_pkg::BIT_PVER]) |-> st_ff.ver[0])
    else $error("verify refused under error");

  // Select zero redirects the first window of block zero
  a_overlay_zero : assert property (
    @(posedge clock) disable iff (!reset_n)
    ce && st_ff.emu == 4'h8 && st_ff.umode_s2 && cpu_addr[31:12] == 20'h0
    |=> st_ff.ovl_redirect)
    else $error("overlay of block zero missing");

endmodule : flash_protect

//--- test_flash_protect.sv
// Self-checking bench for flash_protect: registers, CPU events, pins.
// Assumes the design carries its own assertions; the bench drives every port.
`timescale 1ns/1ps
`define CHK(a, e) begin n_checks++; if ((a) !== (e)) begin bad_count++; \
  $display("MISMATCH t=%0t got %h exp %h", $time, (a), (e)); end end
module test_flash_protect;
  logic        clock = 1'b0, reset_n = 1'b0, ce = 1'b1;   // Clock, reset, enable
  logic [7:0]  s_axi_awaddr = '0, s_axi_araddr = '0;      // Register addresses
  logic [31:0] s_axi_wdata = '0, s_axi_rdata, cpu_addr = '0, ovl_ram_addr, rv;
  logic [3:0]  s_axi_wstrb = 4'hf;                        // Full word writes
  logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic        s_axi_arvalid = 1'b0, s_axi_rready = 1'b0, s_axi_awready, s_axi_wready;
  logic        s_axi_bvalid, s_axi_arready, s_axi_rvalid, cpu_read = 1'b0;
  logic        cpu_sleep = 1'b0, hw_standby = 1'b0, user_mode = 1'b1;
  logic [1:0]  s_axi_bresp, s_axi_rresp, program_mode, erase_mode, verify_mode, rr;
  logic [15:0] erase_target;                              // Blocks under erase
  logic        flash_error_flag, ovl_redirect, ovl_refuse;
  logic [7:0]  b;                                         // Random block mask
  int          bad_count = 0, n_checks = 0;
  // 25 MHz system clock
  always #20 clock = ~clock;
  flash_protect DUT (.clock, .reset_n, .ce, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
    .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
    .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .cpu_read, .cpu_addr, .cpu_sleep,
    .hw_standby, .user_mode, .program_mode, .erase_mode, .verify_mode, .erase_target,
    .flash_error_flag, .ovl_redirect, .ovl_refuse, .ovl_ram_addr);
  // Verdict and end of run
  task close_out;
    $display("checks %0d mismatches %0d", n_checks, bad_count);
    if (bad_count == 0 && n_checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : close_out
  // Stored control value: program/erase bits drop while the area is protected
  function automatic logic [7:0] exp_ctrl(input logic [7:0] old, nw, input logic emu);
    return (nw & flash_protect_pkg::CTRL_WMASK) & ((old[6] && !emu) ? 8'hff : 8'hfc);
  endfunction : exp_ctrl
  // AXI write; each channel released at the edge that takes it
  task wr(input logic [7:0] a, input logic [7:0] d);
    logic aw, w, bh;
    @(posedge clock);
    {s_axi_awaddr, s_axi_wdata} <= {a, 24'h0, d};
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'b111;
    bh = 1'b0;
    while (!bh) begin
      #1;
      aw = s_axi_awvalid & s_axi_awready;
      w = s_axi_wvalid & s_axi_wready;
      bh = s_axi_bvalid;
      rr = s_axi_bresp;
      @(posedge clock);
      if (aw) s_axi_awvalid <= 1'b0;
      if (w) s_axi_wvalid <= 1'b0;
    end
    s_axi_bready <= 1'b0;
  endtask : wr
  // AXI read; data taken at the handshake edge
  task rd(input logic [7:0] a);
    logic ar, h;
    @(posedge clock);
    {s_axi_araddr, s_axi_arvalid, s_axi_rready} <= {a, 2'b11};
    h = 1'b0;
    while (!h) begin
      #1;
      ar = s_axi_arvalid & s_axi_arready;
      {h, rv, rr} = {s_axi_rvalid, s_axi_rdata, s_axi_rresp};
      @(posedge clock);
      if (ar) s_axi_arvalid <= 1'b0;
    end
    s_axi_rready <= 1'b0;
  endtask : rd
  // One-cycle CPU event; registered results show one edge later
  // CPU side never raises a non-maskable interrupt nor writes a timer first
  task ev(input logic r, s, input logic [31:0] a);
    @(posedge clock);
    {cpu_read, cpu_sleep, cpu_addr} <= {r, s, a};
    @(posedge clock);
    {cpu_read, cpu_sleep} <= 2'b00;
    #1;
  endtask : ev
  // Modes follow a register commit by one edge
  task settle;
    repeat (2) @(posedge clock);
    #1;
  endtask : settle
  initial begin
    void'($urandom(27346));
    repeat (8) @(posedge clock);
    reset_n <= 1'b1;
    wr(flash_protect_pkg::OFF_CTRL_LOW, 8'h41);
    rd(flash_protect_pkg::OFF_CTRL_LOW);
    `CHK(rv[7:0], exp_ctrl(8'h00, 8'h41, 1'b0))
    settle;
    `CHK(program_mode, 2'b00)
    wr(flash_protect_pkg::OFF_CTRL_LOW, 8'h41);
    settle;
    `CHK(program_mode, 2'b01)
    ev(1'b1, 1'b0, 32'h0004_0000 | ($urandom & 32'h3ffff));
    `CHK(flash_error_flag, 1'b0)
    ev(1'b1, 1'b0, $urandom & 32'h3ffff);
    `CHK(flash_error_flag, 1'b1)
    `CHK(program_mode, 2'b00)
    rd(flash_protect_pkg::OFF_CTRL_LOW);
    `CHK(rv[7:0], 8'h41)
    wr(flash_protect_pkg::OFF_CTRL_LOW, 8'h45);
    settle;
    `CHK(program_mode, 2'b00)
    `CHK(verify_mode, 2'b01)
    wr(flash_protect_pkg::OFF_CTRL_HIGH, 8'h00);
    rd(flash_protect_pkg::OFF_CTRL_HIGH);
    `CHK(rv[7], 1'b1)
    @(posedge clock);
    hw_standby <= 1'b1;
    repeat (4) @(posedge clock);
    hw_standby <= 1'b0;
    settle;
    `CHK(flash_error_flag, 1'b0)
    wr(flash_protect_pkg::OFF_CTRL_LOW, 8'h40);
    wr(flash_protect_pkg::OFF_CTRL_LOW, 8'h42);
    settle;
    `CHK(erase_mode, 2'b00)
    b = 8'($urandom_range(255, 1));
    wr(flash_protect_pkg::OFF_EBS_ONE, b);
    settle;
    `CHK(erase_target, {8'h00, b})
    ev(1'b0, 1'b1, 32'h0);
    `CHK(flash_error_flag, 1'b1)
    // Software clears the area enable and waits before applying reset
    wr(flash_protect_pkg::OFF_CTRL_LOW, 8'h00);
    repeat (flash_protect_pkg::CSWE_CYCLES) @(posedge clock);
    @(posedge clock);
    reset_n <= 1'b0;
    repeat (2) @(posedge clock);
    reset_n <= 1'b1;
    settle;
    `CHK(flash_error_flag, 1'b0)
    wr(flash_protect_pkg::OFF_CTRL_HIGH, 8'hc0);
    `CHK(flash_error_flag, 1'b0)
    wr(flash_protect_pkg::OFF_CTRL_HIGH, 8'h41);
    settle;
    `CHK(program_mode, 2'b10)
    // Emulation select must drop a running program mode
    wr(flash_protect_pkg::OFF_EMU, 8'h08);
    settle;
    `CHK(program_mode, 2'b00)
    ev(1'b0, 1'b0, $urandom & 32'hfff);
    `CHK(ovl_redirect, 1'b1)
    `CHK(ovl_ram_addr, flash_protect_pkg::RAM_OVL_BASE | {20'h0, cpu_addr[11:0]})
    ev(1'b0, 1'b0, flash_protect_pkg::RAM_OVL_BASE | ($urandom & 32'hfff));
    `CHK(ovl_refuse, 1'b1)
    // Outside user modes the overlay must stay off
    @(posedge clock);
    user_mode <= 1'b0;
    settle;
    ev(1'b0, 1'b0, $urandom & 32'hfff);
    `CHK(ovl_redirect, 1'b0)
    @(posedge clock);
    user_mode <= 1'b1;
    settle;
    wr(flash_protect_pkg::OFF_EMU, 8'h00);
    `CHK(rr, flash_protect_pkg::RESP_OKAY)
    ev(1'b0, 1'b0, 32'h100);
    `CHK(ovl_redirect, 1'b0)
    wr(8'h18, 8'hff);
    `CHK(rr, flash_protect_pkg::RESP_SLVERR)
    rd(8'h18);
    `CHK(rr, flash_protect_pkg::RESP_SLVERR)
    close_out;
  end
  // Hang guard, far beyond the few thousand cycles the tests need
  initial begin
    #1000000;
    bad_count++;
    close_out;
  end
endmodule : test_flash_protect
